// *** testbench/dvo_far_end_model.sv ***
/*
 * far-side encoder or panel: pixel clock, interrupt and field/stall pins.
 * assumes the bench steers it; its pixel clock has a 200 ns period.
 */
`timescale 1ns/10ps

module dvo_far_end_model
(
	input wire logic i_run,
	input wire logic i_level,
	input wire logic i_irq,
	input wire logic [1:0] i_fs,
	output logic o_pixclk,
	output logic o_irq_n,
	output logic [1:0] o_fs
);
	logic clk_q = 1'b0;

	// clock stands still outside runs; idle pin follows the level at once
	always #100 clk_q = i_run ? ~clk_q : 1'b0;
	assign o_pixclk = i_run ? clk_q : i_level;
	assign o_irq_n = ~i_irq;
	assign o_fs = i_fs;
endmodule

// *** testbench/dvo_out_port_assertions.sv ***
/*
 * concurrent checks on the video output port pins.
 * assumes it is bound to dvo_out_port and sees only its ports.
 */
`timescale 1ns/10ps
`include "dvo_port_map.svh"

module dvo_out_port_assertions
	import dvo_port_pkg::*;
#(
	parameter int LINE_PIXELS = 8
)
(
	input wire logic I_CLK_SYS,
	input wire logic I_SRST,
	input wire chan_cfg_t I_CHAN_B_CFG,
	input wire pix_beat_t I_CHAN_B_BEAT,
	input wire logic I_CHAN_B_VALID,
	input wire logic I_SHARED_IRQ_IN_N,
	input wire logic I_SHARED_IRQ_TO_C,
	input wire logic O_CHAN_B_READY,
	input wire logic O_CHAN_B_CLOCK_PAIR_P,
	input wire logic O_CHAN_B_CLOCK_PAIR_N,
	input wire logic [`DVO_HALF_BITS-1:0] O_CHAN_B_PIXEL_BUS,
	input wire logic O_CHAN_B_LINE_SYNC,
	input wire logic O_CHAN_B_FRAME_SYNC,
	input wire logic O_CHAN_B_ACTIVE_INDICATOR_N,
	input wire logic O_CHAN_C_IRQ,
	input wire logic O_DISPLAY_CTRL_SERIAL_CLOCK_OE
);
	default clocking cb @(posedge I_CLK_SYS);
	endclocking
	default disable iff (I_SRST);

	property p_scl_reset;
		disable iff (1'b0) I_SRST |-> !O_DISPLAY_CTRL_SERIAL_CLOCK_OE;
	endproperty
	a_scl_reset: assert property (p_scl_reset)
		else $error("serial clock driven in reset");

	property p_pair;
		O_CHAN_B_CLOCK_PAIR_N == !O_CHAN_B_CLOCK_PAIR_P;
	endproperty
	a_pair: assert property (p_pair)
		else $error("clock pair not complementary");

	property p_half;
		O_CHAN_B_CLOCK_PAIR_P |=> !O_CHAN_B_CLOCK_PAIR_P;
	endproperty
	a_half: assert property (p_half)
		else $error("clock high longer than one cycle");

	property p_halves;
		I_CHAN_B_VALID && O_CHAN_B_READY |=> O_CHAN_B_CLOCK_PAIR_P &&
			O_CHAN_B_PIXEL_BUS == $past(I_CHAN_B_BEAT.data[11:0]) ##1
			O_CHAN_B_PIXEL_BUS == $past(I_CHAN_B_BEAT.data[23:12], 2);
	endproperty
	a_halves: assert property (p_halves)
		else $error("pixel halves wrong");

	property p_sync;
		I_CHAN_B_VALID && O_CHAN_B_READY |=> O_CHAN_B_LINE_SYNC ==
			($past(I_CHAN_B_BEAT.line_sync) ~^ $past(I_CHAN_B_CFG.line_pol)) &&
			O_CHAN_B_FRAME_SYNC ==
			($past(I_CHAN_B_BEAT.frame_sync) ~^ $past(I_CHAN_B_CFG.frame_pol));
	endproperty
	a_sync: assert property (p_sync)
		else $error("sync polarity wrong");

	property p_ind;
		I_CHAN_B_VALID && O_CHAN_B_READY |=> O_CHAN_B_ACTIVE_INDICATOR_N ==
			!($past(I_CHAN_B_BEAT.active) | $past(I_CHAN_B_CFG.border_mode) &
			$past(I_CHAN_B_BEAT.border));
	endproperty
	a_ind: assert property (p_ind)
		else $error("indicator wrong");

	property p_align;
		$rose(O_CHAN_B_CLOCK_PAIR_P) |=> $stable(O_CHAN_B_LINE_SYNC) &&
			$stable(O_CHAN_B_FRAME_SYNC) && $stable(O_CHAN_B_ACTIVE_INDICATOR_N);
	endproperty
	a_align: assert property (p_align)
		else $error("sync changed mid period");

	property p_irq;
		(!I_SHARED_IRQ_IN_N && I_SHARED_IRQ_TO_C) [*4] |-> O_CHAN_C_IRQ;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt not raised");
endmodule

bind dvo_out_port dvo_out_port_assertions #(.LINE_PIXELS(LINE_PIXELS))
	dvo_out_port_assertions_inst (.*);

// *** testbench/dvo_out_port_tb.sv ***
/*
 * self-checking bench for dvo_out_port with a queue model of the beats.
 * assumes the far-end model and the bound checker are compiled.
 */
`timescale 1ns/10ps

module dvo_out_port_tb;
	import dvo_port_pkg::*;
	logic clk = 1'b0, srst = 1'b1, pull = 1'b1, run = 1'b0, lvl = 1'b0;
	logic irq = 1'b0, as_irq = 1'b0, pix_c = 1'b0, irq_c = 1'b0;
	logic vmode, rise, oe, pin_pix, pin_irq_n;
	logic [1:0] valid = 2'h0, fs = 2'h0, tk = 2'h0, hv = 2'h0;
	logic [1:0] rdy, pp, pn, ls, vs, ind, fld, irqo, pin_fs;
	logic [11:0] bus [2];
	chan_cfg_t cfg [2];
	pix_beat_t beat [2];
	pix_beat_t hb [2];
	pix_beat_t eq [2][$];
	int miscompares = 0, comparisons = 0, run_lo = 0, max_lo = 0, rises = 0;

	always #12.5 clk = ~clk;

	dvo_far_end_model dvo_far_end_model_inst (.i_run(run), .i_level(lvl),
		.i_irq(irq), .i_fs(fs), .o_pixclk(pin_pix), .o_irq_n(pin_irq_n),
		.o_fs(pin_fs));

	dvo_out_port #(.LINE_PIXELS(8)) dvo_out_port_inst (.I_CLK_SYS(clk),
		.I_SRST(srst), .I_PORT_MODE_STRAP(1'b1), .I_CHAN_B_CFG(cfg[0]),
		.I_CHAN_C_CFG(cfg[1]), .I_CHAN_B_BEAT(beat[0]),
		.I_CHAN_B_VALID(valid[0]), .I_CHAN_C_BEAT(beat[1]),
		.I_CHAN_C_VALID(valid[1]), .I_CHAN_B_FIELD_OR_STALL_IN(pin_fs[0]),
		.I_CHAN_C_FIELD_OR_STALL_IN(pin_fs[1]),
		.I_SHARED_PIXCLK_OR_IRQ_IN(pin_pix), .I_PIXCLK_AS_IRQ(as_irq),
		.I_PIXCLK_IRQ_TO_C(pix_c), .I_SHARED_IRQ_IN_N(pin_irq_n),
		.I_SHARED_IRQ_TO_C(irq_c), .I_DISPLAY_CTRL_SERIAL_CLOCK_IN(~oe),
		.I_SERIAL_CLOCK_PULL_LOW(pull), .O_VIDEO_MODE(vmode),
		.O_CHAN_B_READY(rdy[0]), .O_CHAN_C_READY(rdy[1]),
		.O_CHAN_B_CLOCK_PAIR_P(pp[0]), .O_CHAN_B_CLOCK_PAIR_N(pn[0]),
		.O_CHAN_B_PIXEL_BUS(bus[0]), .O_CHAN_B_LINE_SYNC(ls[0]),
		.O_CHAN_B_FRAME_SYNC(vs[0]), .O_CHAN_B_ACTIVE_INDICATOR_N(ind[0]),
		.O_CHAN_C_CLOCK_PAIR_P(pp[1]), .O_CHAN_C_CLOCK_PAIR_N(pn[1]),
		.O_CHAN_C_PIXEL_BUS(bus[1]), .O_CHAN_C_LINE_SYNC(ls[1]),
		.O_CHAN_C_FRAME_SYNC(vs[1]), .O_CHAN_C_ACTIVE_INDICATOR_N(ind[1]),
		.O_CHAN_B_OVERLAY_FIELD(fld[0]), .O_CHAN_C_OVERLAY_FIELD(fld[1]),
		.O_CHAN_B_STALLED(), .O_CHAN_C_STALLED(), .O_PLL_REF_CLK(),
		.O_PLL_REF_RISE(rise), .O_CHAN_B_IRQ(irqo[0]), .O_CHAN_C_IRQ(irqo[1]),
		.O_DISPLAY_CTRL_SERIAL_CLOCK_OUT(),
		.O_DISPLAY_CTRL_SERIAL_CLOCK_OE(oe),
		.O_DISPLAY_CTRL_SERIAL_CLOCK_LEVEL());

	task automatic check(input logic ok, input string m);
		comparisons++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	task automatic give_verdict;
		if (miscompares == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	function automatic pix_beat_t want(pix_beat_t b, chan_cfg_t f);
		want = b;
		want.line_sync = b.line_sync ~^ f.line_pol;
		want.frame_sync = b.frame_sync ~^ f.frame_pol;
		want.active = !(b.active | (f.border_mode & b.border));
	endfunction

	function automatic logic same(pix_beat_t e, logic [11:0] b, int c);
		return bus[c] === b && ls[c] === e.line_sync &&
			vs[c] === e.frame_sync && ind[c] === e.active;
	endfunction

	task automatic stream(input int n);
		valid = 2'h3;
		repeat (n)
		begin
			@(negedge clk);
			for (int c = 0; c < 2; c++)
				if (tk[c])
					beat[c] = pix_beat_t'(28'($urandom));
			tk = 2'h0;
		end
		valid = 2'h0;
		repeat (4) @(negedge clk);
	endtask

	// model of takes, and stall length as a run of refusals
	always @(posedge clk)
	begin
		rises = rises + int'(rise === 1'b1);
		run_lo = (valid[0] && rdy[0] !== 1'b1) ? run_lo + 1 : 0;
		if (run_lo > max_lo)
			max_lo = run_lo;
		for (int c = 0; c < 2; c++)
			if (valid[c] && rdy[c] === 1'b1)
			begin
				eq[c].push_back(want(beat[c], cfg[c]));
				tk[c] = 1'b1;
			end
	end

	always @(negedge clk)
		for (int c = 0; c < 2; c++)
		begin
			check(pn[c] === ~pp[c], "pair");
			if (hv[c])
				check(same(hb[c], hb[c].data[23:12], c), "half 2");
			hv[c] = 1'b0;
			if (pp[c] === 1'b1 && eq[c].size() > 0)
			begin
				hb[c] = eq[c].pop_front();
				hv[c] = 1'b1;
				check(same(hb[c], hb[c].data[11:0], c), "half 1");
			end
		end

	initial
	begin
		#400000;
		miscompares++;
		give_verdict();
	end

	initial
	begin
		void'($urandom(32'h6661));
		cfg[0] = '0;
		cfg[1] = '0;
		beat[0] = pix_beat_t'(28'($urandom));
		beat[1] = pix_beat_t'(28'($urandom));
		repeat (10) @(negedge clk);
		check(oe === 1'b0, "serial clock driven");
		srst = 1'b0;
		pull = 1'b0;
		repeat (20) if (vmode !== 1'b1) @(negedge clk);
		check(vmode === 1'b1, "video mode");
		for (int k = 0; k < 8; k++)
		begin
			cfg[0] = chan_cfg_t'({3'(k), 3'h0});
			cfg[1] = chan_cfg_t'({~3'(k), 3'h0});
			stream(30);
		end
		for (int p = 0; p < 3; p++)
		begin
			cfg[0] = chan_cfg_t'({3'h0, p < 2, 1'b1, p[0]});
			fs = {2{p[0]}};
			stream(8);
			max_lo = 0;
			fs = ~fs;
			stream(40);
			fs = ~fs;
			if (p < 2)
				check(max_lo >= 8 && max_lo <= 12, "stall length");
			else
				check(max_lo == 1, "disabled input");
		end
		for (int k = 0; k < 4; k++)
		begin
			cfg[0] = chan_cfg_t'({3'h0, 2'b10, k[0]});
			cfg[1] = cfg[0];
			fs = {2{k[1]}};
			repeat (6) @(negedge clk);
			check(fld === {2{k[1] ^ k[0]}}, "field");
		end
		for (int k = 0; k < 4; k++)
		begin
			irq_c = k[0];
			pix_c = k[0];
			as_irq = k[1];
			lvl = k[1];
			irq = !k[1];
			repeat (6) @(negedge clk);
			check(irqo === (k[0] ? 2'h2 : 2'h1), "irq on");
			irq = 1'b0;
			lvl = 1'b0;
			repeat (6) @(negedge clk);
			check(irqo === 2'h0, "irq off");
		end
		as_irq = 1'b0;
		rises = 0;
		run = 1'b1;
		repeat (80) @(negedge clk);
		run = 1'b0;
		check(rises >= 9 && rises <= 11, "pll reference");
		give_verdict();
	end
endmodule

// *** verilog/dvo_lane.sv ***
/*
 * one video output channel: clock pair, double-edge pixel bus,
 * line/frame sync and active indicator, launched with the rising clock edge and the low half.
 * assumes beats come from logic on the same clock as i_clk.
 */
`timescale 1ns/10ps

module dvo_lane
	import dvo_port_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_en,
	input wire chan_cfg_t i_cfg,
	input wire pix_beat_t i_beat,
	input wire logic i_valid,
	input wire logic i_hold,
	output logic o_ready,
	output logic o_line_start,
	output logic o_clk_p,
	output logic o_clk_n,
	output logic [`DVO_HALF_BITS-1:0] o_bus,
	output logic o_line_sync,
	output logic o_frame_sync,
	output logic o_active_n
);

	half_t phase_ff, nxt_phase;
	pix_beat_t beat_ff, nxt_beat;
	logic clk_ff, nxt_clk;
	logic [`DVO_HALF_BITS-1:0] bus_ff, nxt_bus;
	logic ls_ff, nxt_ls;
	logic fs_ff, nxt_fs;
	logic act_n_ff, nxt_act_n;
	logic prev_ls_ff, nxt_prev_ls;
	logic take;
	pix_beat_t cur;

	assign o_ready = i_en & (phase_ff == PH_LOW_HALF) & ~i_hold;
	assign o_line_start = i_valid & i_beat.line_sync & ~prev_ls_ff;
	assign o_clk_p = clk_ff;
	assign o_clk_n = ~clk_ff; // [R2]
	assign o_bus = bus_ff;
	assign o_line_sync = ls_ff;
	assign o_frame_sync = fs_ff;
	assign o_active_n = act_n_ff;

	always_comb
	begin
		take = i_valid & o_ready;
		cur = take ? i_beat : '0;
		nxt_phase = phase_ff;
		nxt_beat = beat_ff;
		nxt_clk = clk_ff;
		nxt_bus = bus_ff;
		nxt_ls = ls_ff;
		nxt_fs = fs_ff;
		nxt_act_n = act_n_ff;
		nxt_prev_ls = prev_ls_ff;
		if (!i_en)
		begin
			nxt_phase = PH_LOW_HALF;
			nxt_beat = '0;
			nxt_clk = 1'b0;
			nxt_bus = '0;
			nxt_ls = ~i_cfg.line_pol;
			nxt_fs = ~i_cfg.frame_pol;
			nxt_act_n = 1'b1;
			nxt_prev_ls = 1'b0;
		end
		else if (phase_ff == PH_LOW_HALF)
		begin
			// rising edge: low half plus syncs go out together
			nxt_phase = PH_HIGH_HALF;
			nxt_beat = cur;
			nxt_clk = 1'b1; // [R2]
			nxt_bus = cur.data[`DVO_HALF_BITS-1:0]; // [R1]
			nxt_ls = ~(cur.line_sync ^ i_cfg.line_pol); // [R3] [R14]
			nxt_fs = ~(cur.frame_sync ^ i_cfg.frame_pol); // [R3] [R14]
			if (i_cfg.border_mode)
				nxt_act_n = ~(cur.active | cur.border); // [R5] [R14]
			else
				nxt_act_n = ~cur.active; // [R4] [R14]
			if (take)
				nxt_prev_ls = cur.line_sync;
		end
		else
		begin
			// falling edge: upper half of the same pixel
			nxt_phase = PH_LOW_HALF;
			nxt_clk = 1'b0;
			nxt_bus = beat_ff.data[`DVO_PIX_BITS-1:`DVO_HALF_BITS]; // [R1]
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			phase_ff <= PH_LOW_HALF;
			beat_ff <= '0;
			clk_ff <= 1'b0;
			bus_ff <= '0;
			ls_ff <= 1'b0;
			fs_ff <= 1'b0;
			act_n_ff <= 1'b1;
			prev_ls_ff <= 1'b0;
		end
		else
		begin
			phase_ff <= nxt_phase;
			beat_ff <= nxt_beat;
			clk_ff <= nxt_clk;
			bus_ff <= nxt_bus;
			ls_ff <= nxt_ls;
			fs_ff <= nxt_fs;
			act_n_ff <= nxt_act_n;
			prev_ls_ff <= nxt_prev_ls;
		end
	end

endmodule

// *** verilog/dvo_out_port.sv ***
/*
 * dual digital video output port: channels b and c, shared pixel
 * clock/interrupt input, shared interrupt input, field/stall inputs,
 * port-mode strap and the display-control serial clock pin.
 * assumes pin inputs are asynchronous to I_CLK_SYS; pixel beats and
 * configuration come from logic on I_CLK_SYS.
 */
// Summary of operation
// R1 - each channel sends 12 bits on each output clock edge, 24 per period.
// R2 - each channel drives a true/complement clock pair, at most 165 MHz.
// R3 - line and frame sync polarity of each channel is set by software.
// R4 - in blank mode the indicator marks active pixels without the border.
// R5 - in border mode the indicator marks active pixels and border pixels.
// R6 - the shared pixel clock input can be the dot clock pll reference.
// R7 - the shared pixel clock input can instead be an interrupt of b or c.
// R8 - in field mode the field input aligns the overlay field to the encoder.
// R9 - in stall mode an asserted input holds the pixel pipe for one line.
// R10 - field/stall polarity is selectable and a disabled input is ignored.
// R11 - the shared interrupt input is accepted for either channel.
// R12 - the serial clock pin is not driven while reset is held.
// R13 - a strap on the shared pin selects graphics port or video channels.
// R14 - sync and indicator outputs change on the same edge as pixel data.
`timescale 1ns/10ps

module dvo_out_port
	import dvo_port_pkg::*;
#(
	parameter int LINE_PIXELS = `DVO_LINE_PIXELS
)
(
	input wire logic I_CLK_SYS,
	input wire logic I_SRST,
	input wire logic I_PORT_MODE_STRAP,
	input wire chan_cfg_t I_CHAN_B_CFG,
	input wire chan_cfg_t I_CHAN_C_CFG,
	input wire pix_beat_t I_CHAN_B_BEAT,
	input wire logic I_CHAN_B_VALID,
	input wire pix_beat_t I_CHAN_C_BEAT,
	input wire logic I_CHAN_C_VALID,
	input wire logic I_CHAN_B_FIELD_OR_STALL_IN,
	input wire logic I_CHAN_C_FIELD_OR_STALL_IN,
	input wire logic I_SHARED_PIXCLK_OR_IRQ_IN,
	input wire logic I_PIXCLK_AS_IRQ,
	input wire logic I_PIXCLK_IRQ_TO_C,
	input wire logic I_SHARED_IRQ_IN_N,
	input wire logic I_SHARED_IRQ_TO_C,
	input wire logic I_DISPLAY_CTRL_SERIAL_CLOCK_IN,
	input wire logic I_SERIAL_CLOCK_PULL_LOW,
	output logic O_VIDEO_MODE,
	output logic O_CHAN_B_READY,
	output logic O_CHAN_C_READY,
	output logic O_CHAN_B_CLOCK_PAIR_P,
	output logic O_CHAN_B_CLOCK_PAIR_N,
	output logic [`DVO_HALF_BITS-1:0] O_CHAN_B_PIXEL_BUS,
	output logic O_CHAN_B_LINE_SYNC,
	output logic O_CHAN_B_FRAME_SYNC,
	output logic O_CHAN_B_ACTIVE_INDICATOR_N,
	output logic O_CHAN_C_CLOCK_PAIR_P,
	output logic O_CHAN_C_CLOCK_PAIR_N,
	output logic [`DVO_HALF_BITS-1:0] O_CHAN_C_PIXEL_BUS,
	output logic O_CHAN_C_LINE_SYNC,
	output logic O_CHAN_C_FRAME_SYNC,
	output logic O_CHAN_C_ACTIVE_INDICATOR_N,
	output logic O_CHAN_B_OVERLAY_FIELD,
	output logic O_CHAN_C_OVERLAY_FIELD,
	output logic O_CHAN_B_STALLED,
	output logic O_CHAN_C_STALLED,
	output logic O_PLL_REF_CLK,
	output logic O_PLL_REF_RISE,
	output logic O_CHAN_B_IRQ,
	output logic O_CHAN_C_IRQ,
	output logic O_DISPLAY_CTRL_SERIAL_CLOCK_OUT,
	output logic O_DISPLAY_CTRL_SERIAL_CLOCK_OE,
	output logic O_DISPLAY_CTRL_SERIAL_CLOCK_LEVEL
);

	localparam logic [`DVO_LINE_CNT_BITS-1:0] LINE_LAST =
		`DVO_LINE_CNT_BITS'(LINE_PIXELS - 1);

	// pin synchronisers: first stage read only by the second
	logic [1:0] fsin_s1_ff, fsin_s2_ff;
	logic pclk_s1_ff, pclk_s2_ff, pclk_prev_ff;
	logic irq_s1_ff, irq_s2_ff;
	logic strap_s1_ff, strap_s2_ff;
	logic scl_s1_ff, scl_s2_ff;

	// strap capture and serial clock drive
	logic strap_done_ff, nxt_strap_done;
	logic video_mode_ff, nxt_video_mode;
	logic scl_pull_ff, nxt_scl_pull;
	logic [1:0] fill_ff, nxt_fill;

	// per channel field/stall state, index 0 is b, 1 is c
	chan_cfg_t cfg [2];
	pix_beat_t beat [2];
	logic [1:0] valid, ready, line_start, hold, fs_eff;
	fs_state_t fs_state_ff [2];
	fs_state_t nxt_fs_state [2];
	logic [`DVO_LINE_CNT_BITS-1:0] line_cnt_ff [2];
	logic [`DVO_LINE_CNT_BITS-1:0] nxt_line_cnt [2];
	logic [1:0] fs_prev_ff, nxt_fs_prev;
	logic [1:0] field_ff, nxt_field;
	logic [1:0] pend_ff, nxt_pend;

	// irq and pll reference
	logic irq_b_ff, nxt_irq_b, irq_c_ff, nxt_irq_c;
	logic pref_ff, nxt_pref, prise_ff, nxt_prise;

	assign cfg[0] = I_CHAN_B_CFG;
	assign cfg[1] = I_CHAN_C_CFG;
	assign beat[0] = I_CHAN_B_BEAT;
	assign beat[1] = I_CHAN_C_BEAT;
	assign valid = {I_CHAN_C_VALID, I_CHAN_B_VALID};

	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
		begin
			fsin_s1_ff <= `DVO_SYNC_RST;
			fsin_s2_ff <= `DVO_SYNC_RST;
			{pclk_s1_ff, pclk_s2_ff, pclk_prev_ff} <= 3'h0;
			{irq_s1_ff, irq_s2_ff} <= 2'h3;
			{strap_s1_ff, strap_s2_ff} <= 2'h0;
			{scl_s1_ff, scl_s2_ff} <= 2'h3;
		end
		else
		begin
			fsin_s1_ff <= {I_CHAN_C_FIELD_OR_STALL_IN,
				I_CHAN_B_FIELD_OR_STALL_IN};
			fsin_s2_ff <= fsin_s1_ff;
			pclk_s1_ff <= I_SHARED_PIXCLK_OR_IRQ_IN;
			pclk_s2_ff <= pclk_s1_ff;
			pclk_prev_ff <= pclk_s2_ff;
			irq_s1_ff <= I_SHARED_IRQ_IN_N;
			irq_s2_ff <= irq_s1_ff;
			strap_s1_ff <= I_PORT_MODE_STRAP;
			strap_s2_ff <= strap_s1_ff;
			scl_s1_ff <= I_DISPLAY_CTRL_SERIAL_CLOCK_IN;
			scl_s2_ff <= scl_s1_ff;
		end
	end

	// strap caught once, after the synchroniser has filled
	always_comb
	begin
		nxt_strap_done = strap_done_ff;
		nxt_video_mode = video_mode_ff;
		nxt_scl_pull = I_SERIAL_CLOCK_PULL_LOW;
		nxt_fill = fill_ff;
		// wait two edges so the second stage holds the pin
		if (!fill_ff[1])
			nxt_fill = fill_ff + 2'h1;
		if (!strap_done_ff && fill_ff[1])
		begin
			nxt_video_mode = strap_s2_ff; // [R13]
			nxt_strap_done = 1'b1;
		end
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
		begin
			strap_done_ff <= 1'b0;
			fill_ff <= 2'h0;
			video_mode_ff <= `DVO_STRAP_RST;
			scl_pull_ff <= `DVO_SCL_OE_RST;
		end
		else
		begin
			strap_done_ff <= nxt_strap_done;
			fill_ff <= nxt_fill;
			video_mode_ff <= nxt_video_mode;
			scl_pull_ff <= nxt_scl_pull;
		end
	end

	assign O_VIDEO_MODE = video_mode_ff;
	assign O_DISPLAY_CTRL_SERIAL_CLOCK_OUT = 1'b0;
	assign O_DISPLAY_CTRL_SERIAL_CLOCK_OE = scl_pull_ff & ~I_SRST; // [R12]
	assign O_DISPLAY_CTRL_SERIAL_CLOCK_LEVEL = scl_s2_ff;

	// field/stall handling, one copy per channel
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			fs_eff[i] = cfg[i].fs_en & (fsin_s2_ff[i] ^ cfg[i].fs_pol); // [R10]
			nxt_fs_prev[i] = fs_eff[i];
			nxt_field[i] = field_ff[i];
			nxt_pend[i] = pend_ff[i];
			nxt_fs_state[i] = fs_state_ff[i];
			nxt_line_cnt[i] = line_cnt_ff[i];
			hold[i] = 1'b0;
			if (cfg[i].fs_en & ~cfg[i].fs_stall)
				nxt_field[i] = fs_eff[i]; // [R8]
			case (fs_state_ff[i])
				FS_IDLE:
				begin
					if (cfg[i].fs_en & cfg[i].fs_stall & fs_eff[i]
						& ~fs_prev_ff[i])
						nxt_fs_state[i] = FS_ARMED; // [R9]
				end
				FS_ARMED:
				begin
					if (!(cfg[i].fs_en & cfg[i].fs_stall))
						nxt_fs_state[i] = FS_IDLE; // [R10]
					else if (line_start[i])
					begin
						hold[i] = 1'b1; // [R9]
						nxt_line_cnt[i] = '0;
						nxt_fs_state[i] = FS_HOLD;
					end
				end
				FS_HOLD:
				begin
					hold[i] = 1'b1; // [R9]
					if (line_cnt_ff[i] == LINE_LAST)
						nxt_fs_state[i] = FS_IDLE;
					else
						nxt_line_cnt[i] = line_cnt_ff[i] + 1'b1;
				end
				default:
				begin
					nxt_fs_state[i] = FS_IDLE;
				end
			endcase
			nxt_pend[i] = fs_state_ff[i] != FS_IDLE;
		end
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
		begin
			fs_prev_ff <= 2'h0;
			field_ff <= 2'h0;
			pend_ff <= 2'h0;
			for (int i = 0; i < 2; i++)
			begin
				fs_state_ff[i] <= FS_IDLE;
				line_cnt_ff[i] <= '0;
			end
		end
		else
		begin
			fs_prev_ff <= nxt_fs_prev;
			field_ff <= nxt_field;
			pend_ff <= nxt_pend;
			for (int i = 0; i < 2; i++)
			begin
				fs_state_ff[i] <= nxt_fs_state[i];
				line_cnt_ff[i] <= nxt_line_cnt[i];
			end
		end
	end

	assign O_CHAN_B_OVERLAY_FIELD = field_ff[0];
	assign O_CHAN_C_OVERLAY_FIELD = field_ff[1];
	assign O_CHAN_B_STALLED = pend_ff[0];
	assign O_CHAN_C_STALLED = pend_ff[1];
	assign O_CHAN_B_READY = ready[0];
	assign O_CHAN_C_READY = ready[1];

	// shared pixel clock input and interrupt routing
	always_comb
	begin
		nxt_pref = ~I_PIXCLK_AS_IRQ & pclk_s2_ff; // [R6]
		nxt_prise = ~I_PIXCLK_AS_IRQ & pclk_s2_ff & ~pclk_prev_ff; // [R6]
		nxt_irq_b = (~irq_s2_ff & ~I_SHARED_IRQ_TO_C) // [R11]
			| (I_PIXCLK_AS_IRQ & pclk_s2_ff & ~I_PIXCLK_IRQ_TO_C); // [R7]
		nxt_irq_c = (~irq_s2_ff & I_SHARED_IRQ_TO_C) // [R11]
			| (I_PIXCLK_AS_IRQ & pclk_s2_ff & I_PIXCLK_IRQ_TO_C); // [R7]
	end

	always_ff @(posedge I_CLK_SYS)
	begin
		if (I_SRST)
		begin
			pref_ff <= 1'b0;
			prise_ff <= 1'b0;
			irq_b_ff <= 1'b0;
			irq_c_ff <= 1'b0;
		end
		else
		begin
			pref_ff <= nxt_pref;
			prise_ff <= nxt_prise;
			irq_b_ff <= nxt_irq_b;
			irq_c_ff <= nxt_irq_c;
		end
	end

	assign O_PLL_REF_CLK = pref_ff;
	assign O_PLL_REF_RISE = prise_ff;
	assign O_CHAN_B_IRQ = irq_b_ff;
	assign O_CHAN_C_IRQ = irq_c_ff;

	dvo_lane u_lane_b
	(
		.i_clk(I_CLK_SYS),
		.i_rst(I_SRST),
		.i_en(video_mode_ff),
		.i_cfg(cfg[0]),
		.i_beat(beat[0]),
		.i_valid(valid[0]),
		.i_hold(hold[0]),
		.o_ready(ready[0]),
		.o_line_start(line_start[0]),
		.o_clk_p(O_CHAN_B_CLOCK_PAIR_P),
		.o_clk_n(O_CHAN_B_CLOCK_PAIR_N),
		.o_bus(O_CHAN_B_PIXEL_BUS),
		.o_line_sync(O_CHAN_B_LINE_SYNC),
		.o_frame_sync(O_CHAN_B_FRAME_SYNC),
		.o_active_n(O_CHAN_B_ACTIVE_INDICATOR_N)
	);

	dvo_lane u_lane_c
	(
		.i_clk(I_CLK_SYS),
		.i_rst(I_SRST),
		.i_en(video_mode_ff),
		.i_cfg(cfg[1]),
		.i_beat(beat[1]),
		.i_valid(valid[1]),
		.i_hold(hold[1]),
		.o_ready(ready[1]),
		.o_line_start(line_start[1]),
		.o_clk_p(O_CHAN_C_CLOCK_PAIR_P),
		.o_clk_n(O_CHAN_C_CLOCK_PAIR_N),
		.o_bus(O_CHAN_C_PIXEL_BUS),
		.o_line_sync(O_CHAN_C_LINE_SYNC),
		.o_frame_sync(O_CHAN_C_FRAME_SYNC),
		.o_active_n(O_CHAN_C_ACTIVE_INDICATOR_N)
	);

endmodule

// *** verilog/dvo_port_map.svh ***
/*
 * constants for the dual digital video output port: clock figures,
 * divider, reset values and default line length.
 * assumes inclusion by bare name from the package and design files.
 */
`ifndef DVO_PORT_MAP_SVH
`define DVO_PORT_MAP_SVH

`define DVO_SYS_CLK_MHZ 40
`define DVO_MAX_OUT_CLK_MHZ 165
`define DVO_OUT_CLK_DIV 2
`define DVO_OUT_CLK_MHZ (`DVO_SYS_CLK_MHZ / `DVO_OUT_CLK_DIV)
`define DVO_HALF_BITS 12
`define DVO_PIX_BITS 24
`define DVO_LINE_PIXELS 800
`define DVO_LINE_CNT_BITS 16
`define DVO_STRAP_RST 1'b0
`define DVO_SCL_OE_RST 1'b0
`define DVO_SYNC_RST 2'h0

`endif

// *** verilog/dvo_port_pkg.sv ***
/*
 * types shared by the video output port: channel configuration,
 * pixel beat, field/stall and half-period states.
 * assumes dvo_port_map.svh is on the include path.
 */
`include "dvo_port_map.svh"

package dvo_port_pkg;

	typedef struct packed
	{
		logic line_pol;
		logic frame_pol;
		logic border_mode;
		logic fs_en;
		logic fs_stall;
		logic fs_pol;
	} chan_cfg_t;

	typedef struct packed
	{
		logic [`DVO_PIX_BITS-1:0] data;
		logic line_sync;
		logic frame_sync;
		logic active;
		logic border;
	} pix_beat_t;

	typedef enum logic [1:0]
	{
		FS_IDLE = 2'b00,
		FS_ARMED = 2'b01,
		FS_HOLD = 2'b10
	} fs_state_t;

	typedef enum logic
	{
		PH_LOW_HALF = 1'b0,
		PH_HIGH_HALF = 1'b1
	} half_t;

endpackage
